/* File: hdl/pbo_core.sv */
// Purpose: power-operation command entry, enable combine and strap decode
// Assumes: configuration inputs come from logic on clk
// Notes: link writes arrive by toggle; frames are far apart, so no return ack
// Function
// - block bytes travel lowest byte first
// - byte n carries bits 8n+7 to 8n
// - command 01h is the power-operation command
// - same command sets margin and soft stop
// - exactly one data byte, byte read/write
// - ground resistor classified into sixteen codes
// - upper to lower ratio gives divider code
// - bit 7 turns conversion on or off
// - margin field decode, others flagged unsupported
`timescale 1ns/1ps
`default_nettype none
module pbo_core import pbo_pkg::*; #(
   parameter int BLK_BYTES = 4,
   parameter int NUM_STRAPS = 2,
   parameter logic [6:0] DEV_ADDR = PBO_ADDR_DEFAULT
) (
   // clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   // management bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // enable source configuration and enable pin
   input wire logic enable_pin,
   input wire logic cfg_act_on_inputs,
   input wire logic cfg_use_cmd,
   input wire logic cfg_use_pin,
   // unsupported data flag clear
   input wire logic unsupported_clear,
   // strap measurement
   input wire logic strap_sample,
   input wire logic [NUM_STRAPS-1:0][PBO_OHM_W-1:0] strap_rbot_ohms,
   input wire logic [NUM_STRAPS-1:0][PBO_OHM_W-1:0] strap_rtop_ohms,
   // converter control
   output logic conversion_enable,
   output logic soft_stop_sel,
   output pbo_margin_t margin_sel,
   output logic margin_ignore_fault,
   output logic [7:0] operation_value,
   output logic unsupported_data,
   // strap codes
   output logic strap_done,
   output logic [NUM_STRAPS-1:0][3:0] ground_resistor_code,
   output logic [NUM_STRAPS-1:0][3:0] divider_code
);
   localparam int IW = $clog2(BLK_BYTES+1);
   localparam int BW = BLK_BYTES*8;
   typedef struct packed {
      logic [2:0] wr_s; // write toggle synchroniser
      logic wr_seen;
      logic [2:0] en_s; // enable pin synchroniser
      logic en_f;
      logic [7:0] op; // power-operation byte
      logic unsupported;
      logic conv_en;
      logic soft_stop;
      pbo_margin_t margin;
      logic margin_ign;
      logic rd_tgl; // publishes op to the link
      logic [BW-1:0] rd_word;
      logic strap_done;
      logic [NUM_STRAPS-1:0][3:0] gcode;
      logic [NUM_STRAPS-1:0][3:0] dcode;
   } pbo_core_st_t;
   pbo_core_st_t q;
   pbo_core_st_t next_q;
   // link side of the crossing
   logic link_wr_tgl;
   logic [7:0] link_wr_cmd;
   logic [BW-1:0] link_wr_word;
   logic [IW-1:0] link_wr_count;

   // bus slave on the link clock
   pbo_link #(
      .BLK_BYTES(BLK_BYTES),
      .DEV_ADDR(DEV_ADDR)
   ) u_link (
      .link_clk(link_clk),
      .rst(rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_n(sda_oe_n),
      .wr_tgl(link_wr_tgl),
      .wr_cmd(link_wr_cmd),
      .wr_word(link_wr_word),
      .wr_count(link_wr_count),
      .rd_tgl_in(q.rd_tgl),
      .rd_word_in(q.rd_word)
   );

   // margin field check: valid code, kind, and fault-ignore variant
   function automatic logic [3:0] margin_decode(input logic [3:0] f);
      logic [3:0] r; // {valid, ignore, kind}
      unique case (f)
         PBO_MRG_OFF0, PBO_MRG_OFF1, PBO_MRG_OFF2: r = {2'b10, PBO_MARGIN_OFF};
         PBO_MRG_LOW_IGN: r = {2'b11, PBO_MARGIN_LOW};
         PBO_MRG_LOW_ACT: r = {2'b10, PBO_MARGIN_LOW};
         PBO_MRG_HIGH_IGN: r = {2'b11, PBO_MARGIN_HIGH};
         PBO_MRG_HIGH_ACT: r = {2'b10, PBO_MARGIN_HIGH};
         default: r = {2'b00, PBO_MARGIN_OFF};
      endcase
      return r;
   endfunction

   // ground resistor code: number of midpoints at or below the value
   function automatic logic [3:0] ground_class(input logic [PBO_OHM_W-1:0] rb);
      logic [3:0] c;
      c = 4'h0;
      for (int k = 0; k < 15; k++) begin
         if (rb >= PBO_RBOT_THR[k]) c = c + 4'h1;
      end
      return c;
   endfunction

   // divider code: code 0 is the largest upper resistor, ratio falls after
   function automatic logic [3:0] divider_class(input logic [PBO_OHM_W-1:0] rt,
                                                input logic [PBO_OHM_W-1:0] rb);
      logic [3:0] c;
      logic [31:0] lhs;
      c = 4'h0;
      lhs = 32'(rt) << PBO_RATIO_SHIFT;
      for (int k = 0; k < 15; k++) begin
         // compare by product, avoiding a divider
         if (lhs < 32'(rb) * 32'(PBO_RATIO_THR[k])) c = c + 4'h1;
      end
      return c;
   endfunction

   // core next-state logic
   always_comb begin
      logic [3:0] md;
      logic [7:0] wbyte;
      logic wr_evt;
      md = 4'h0;
      wbyte = 8'h00;
      wr_evt = 1'b0;
      next_q = q;
      // pin and toggle pass three stages, change taken when two and three agree
      next_q.en_s = {q.en_s[1:0], enable_pin};
      if (q.en_s[1] == q.en_s[2]) next_q.en_f = q.en_s[2];
      next_q.wr_s = {q.wr_s[1:0], link_wr_tgl};
      wr_evt = (q.wr_s[1] == q.wr_s[2]) && (q.wr_s[2] != q.wr_seen);
      if (wr_evt) next_q.wr_seen = q.wr_s[2];
      // clear first so that a new error in the same cycle wins
      if (unsupported_clear) next_q.unsupported = 1'b0;
      // write of the power-operation command
      if (wr_evt && link_wr_cmd == PBO_CMD_OPERATION) begin
         wbyte = link_wr_word[7:0];
         md = margin_decode(wbyte[PBO_OP_MARGIN_LSB +: 4]);
         if (link_wr_count == IW'(PBO_OP_DATA_BYTES) && md[3]) begin
            next_q.op = wbyte & PBO_OP_WR_MASK;
         end else begin
            // rejected value leaves the register as it was
            next_q.unsupported = 1'b1;
         end
      end
      // publish the stored value to the link for byte reads
      if (next_q.op != q.op) begin
         next_q.rd_word = BW'(next_q.op);
         next_q.rd_tgl = !q.rd_tgl;
      end
      // converter control from the stored byte
      md = margin_decode(next_q.op[PBO_OP_MARGIN_LSB +: 4]);
      next_q.margin = pbo_margin_t'(md[1:0]);
      next_q.margin_ign = md[2] && next_q.op[PBO_OP_ONOFF_BIT];
      next_q.soft_stop = next_q.op[PBO_OP_SOFT_BIT];
      next_q.conv_en = !cfg_act_on_inputs ||
         ((!cfg_use_cmd || next_q.op[PBO_OP_ONOFF_BIT]) &&
          (!cfg_use_pin || next_q.en_f));
      // straps are read once after power-up
      if (strap_sample && !q.strap_done) begin
         next_q.strap_done = 1'b1;
         for (int s = 0; s < NUM_STRAPS; s++) begin
            next_q.gcode[s] = ground_class(strap_rbot_ohms[s]);
            next_q.dcode[s] = divider_class(strap_rtop_ohms[s], strap_rbot_ohms[s]);
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.op <= PBO_OP_RESET;
         q.margin <= PBO_MARGIN_OFF;
         q.conv_en <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from flops
   assign conversion_enable = q.conv_en;
   assign soft_stop_sel = q.soft_stop;
   assign margin_sel = q.margin;
   assign margin_ignore_fault = q.margin_ign;
   assign operation_value = q.op;
   assign unsupported_data = q.unsupported;
   assign strap_done = q.strap_done;
   assign ground_resistor_code = q.gcode;
   assign divider_code = q.dcode;
endmodule
`default_nettype wire

/* File: hdl/pbo_link.sv */
// Purpose: management bus slave on the link clock, assembles block values
// Assumes: bus pins oversampled by a free-running link clock
// Notes: no clock stretching; data bytes past the block width are acked, dropped
`timescale 1ns/1ps
`default_nettype none
module pbo_link import pbo_pkg::*; #(
   parameter int BLK_BYTES = 4,
   parameter logic [6:0] DEV_ADDR = PBO_ADDR_DEFAULT
) (
   // link clock and reset
   input wire logic link_clk,
   input wire logic rst,
   // bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // completed write, held until the next one
   output logic wr_tgl,
   output logic [7:0] wr_cmd,
   output logic [BLK_BYTES*8-1:0] wr_word,
   output logic [$clog2(BLK_BYTES+1)-1:0] wr_count,
   // read value published from the core clock
   input wire logic rd_tgl_in,
   input wire logic [BLK_BYTES*8-1:0] rd_word_in
);
   localparam int IW = $clog2(BLK_BYTES+1);
   localparam int BW = BLK_BYTES*8;
   // one-hot link states
   typedef enum logic [6:0] {
      L_IDLE = 7'b000_0001,
      L_ADDR = 7'b000_0010,
      L_ACK = 7'b000_0100,
      L_CMD = 7'b000_1000,
      L_WDATA = 7'b001_0000,
      L_RDATA = 7'b010_0000,
      L_RACK = 7'b100_0000
   } pbo_lst_t;
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      pbo_lst_t st;
      pbo_lst_t after;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [7:0] cmd;
      logic have_cmd;
      logic rw;
      logic nack;
      logic [BW-1:0] word;
      logic [IW-1:0] cnt;
      logic [IW-1:0] idx;
      logic [2:0] rd_s;
      logic rd_seen;
      logic [BW-1:0] rd_word;
      logic oe_n;
      logic wtg;
      logic [7:0] wcmd;
      logic [BW-1:0] wword;
      logic [IW-1:0] wcnt;
   } pbo_link_st_t;
   pbo_link_st_t q;
   pbo_link_st_t next_q;

   // byte to send at a given index, byte 0 first
   function automatic logic [7:0] tx_byte(input logic [7:0] c, input logic hc,
                                          input logic [IW-1:0] i, input logic [BW-1:0] w);
      logic [7:0] b;
      b = PBO_RD_FILL;
      if (hc && c == PBO_CMD_OPERATION && i < IW'(BLK_BYTES)) begin
         b = w[8*i +: 8];
      end
      return b;
   endfunction

   // whole link state machine
   always_comb begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic [7:0] tb;
      rise = 1'b0;
      fall = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      tb = 8'h00;
      next_q = q;
      // three-stage sampling, level accepted when stages two and three agree
      next_q.scl_s = {q.scl_s[1:0], scl_in};
      next_q.sda_s = {q.sda_s[1:0], sda_in};
      if (q.scl_s[1] == q.scl_s[2]) next_q.scl_f = q.scl_s[2];
      if (q.sda_s[1] == q.sda_s[2]) next_q.sda_f = q.sda_s[2];
      rise = !q.scl_f && next_q.scl_f;
      fall = q.scl_f && !next_q.scl_f;
      start = q.scl_f && next_q.scl_f && q.sda_f && !next_q.sda_f;
      stop = q.scl_f && next_q.scl_f && !q.sda_f && next_q.sda_f;
      // read value from the core: toggle, then stable word
      next_q.rd_s = {q.rd_s[1:0], rd_tgl_in};
      if (q.rd_s[1] == q.rd_s[2] && q.rd_s[2] != q.rd_seen) begin
         next_q.rd_seen = q.rd_s[2];
         next_q.rd_word = rd_word_in;
      end
      if (start) begin
         // also a repeated start; the command byte is kept
         next_q.st = L_ADDR;
         next_q.bitc = 4'h0;
         next_q.oe_n = 1'b1;
      end else if (stop) begin
         // a write frame ends here and is handed to the core
         if (q.have_cmd && !q.rw) begin
            next_q.wtg = !q.wtg;
            next_q.wcmd = q.cmd;
            next_q.wword = q.word;
            next_q.wcnt = q.cnt;
         end
         next_q.st = L_IDLE;
         next_q.have_cmd = 1'b0;
         next_q.oe_n = 1'b1;
      end else if (rise) begin
         unique case (q.st)
            L_ADDR, L_CMD, L_WDATA: begin
               next_q.sh = {q.sh[6:0], next_q.sda_f};
               next_q.bitc = q.bitc + 4'h1;
            end
            L_RDATA: next_q.bitc = q.bitc + 4'h1;
            L_RACK: next_q.nack = next_q.sda_f;
            L_IDLE, L_ACK: ;
         endcase
      end else if (fall) begin
         unique case (q.st)
            L_ADDR: if (q.bitc == 4'h8) begin
               if (q.sh[7:1] == DEV_ADDR) begin
                  next_q.rw = q.sh[0];
                  next_q.after = q.sh[0] ? L_RDATA : L_CMD;
                  next_q.idx = '0;
                  next_q.st = L_ACK;
                  next_q.oe_n = 1'b0;
               end else begin
                  next_q.st = L_IDLE;
               end
            end
            L_CMD: if (q.bitc == 4'h8) begin
               next_q.cmd = q.sh;
               next_q.have_cmd = 1'b1;
               next_q.cnt = '0;
               next_q.word = '0;
               next_q.after = L_WDATA;
               next_q.st = L_ACK;
               next_q.oe_n = 1'b0;
            end
            L_WDATA: if (q.bitc == 4'h8) begin
               // byte n lands in bits 8n+7..8n, first byte lowest
               if (q.cnt < IW'(BLK_BYTES)) begin
                  next_q.word[8*q.cnt +: 8] = q.sh;
                  next_q.cnt = q.cnt + 1'b1;
               end
               next_q.after = L_WDATA;
               next_q.st = L_ACK;
               next_q.oe_n = 1'b0;
            end
            L_ACK: begin
               next_q.bitc = 4'h0;
               next_q.st = q.after;
               tb = tx_byte(q.cmd, q.have_cmd, q.idx, q.rd_word);
               next_q.oe_n = (q.after == L_RDATA) ? tb[7] : 1'b1;
            end
            L_RDATA: begin
               tb = tx_byte(q.cmd, q.have_cmd, q.idx, q.rd_word);
               if (q.bitc == 4'h8) begin
                  next_q.oe_n = 1'b1;
                  next_q.st = L_RACK;
               end else begin
                  next_q.oe_n = tb[3'h7 - q.bitc[2:0]];
               end
            end
            L_RACK: if (!q.nack) begin
               // host wants the next byte, ascending order
               next_q.idx = (q.idx < IW'(BLK_BYTES)) ? q.idx + 1'b1 : q.idx;
               tb = tx_byte(q.cmd, q.have_cmd, next_q.idx, q.rd_word);
               next_q.bitc = 4'h0;
               next_q.st = L_RDATA;
               next_q.oe_n = tb[7];
            end else begin
               next_q.st = L_IDLE;
               next_q.oe_n = 1'b1;
            end
            L_IDLE: ;
         endcase
      end
   end

   // state register, pins idle released
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.scl_s <= 3'h7;
         q.sda_s <= 3'h7;
         q.scl_f <= 1'b1;
         q.sda_f <= 1'b1;
         q.st <= L_IDLE;
         q.after <= L_IDLE;
         q.oe_n <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from flops; the pin is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe_n = q.oe_n;
   assign wr_tgl = q.wtg;
   assign wr_cmd = q.wcmd;
   assign wr_word = q.wword;
   assign wr_count = q.wcnt;
endmodule
`default_nettype wire

/* File: hdl/pbo_pkg.sv */
// Purpose: shared constants and types for the converter command block
// Assumes: 8-bit command codes, one-byte power-operation value
// Notes: strap thresholds sit midway between adjacent nominal resistor values
package pbo_pkg;
   // power-operation command and its byte layout
   localparam logic [7:0] PBO_CMD_OPERATION = 8'h01;
   localparam logic [7:0] PBO_OP_RESET = 8'h00;
   localparam logic [7:0] PBO_OP_WR_MASK = 8'hFC;
   localparam int PBO_OP_ONOFF_BIT = 7;
   localparam int PBO_OP_SOFT_BIT = 6;
   localparam int PBO_OP_MARGIN_LSB = 2;
   localparam logic [2:0] PBO_OP_DATA_BYTES = 3'h1;
   // margin field codes
   localparam logic [3:0] PBO_MRG_OFF0 = 4'h0;
   localparam logic [3:0] PBO_MRG_OFF1 = 4'h1;
   localparam logic [3:0] PBO_MRG_OFF2 = 4'h2;
   localparam logic [3:0] PBO_MRG_LOW_IGN = 4'h5;
   localparam logic [3:0] PBO_MRG_LOW_ACT = 4'h6;
   localparam logic [3:0] PBO_MRG_HIGH_IGN = 4'h9;
   localparam logic [3:0] PBO_MRG_HIGH_ACT = 4'hA;
   // answer for reads of commands this block does not own
   localparam logic [7:0] PBO_RD_FILL = 8'hFF;
   // bus address default, arbitrary value
   localparam logic [6:0] PBO_ADDR_DEFAULT = 7'h2A;
   // strap classification
   localparam int PBO_OHM_W = 19;
   localparam int PBO_RATIO_SHIFT = 8;
   localparam logic [PBO_OHM_W-1:0] PBO_RBOT_THR [0:14] = '{
      19'h0_140A, 19'h0_1847, 19'h0_1D6A, 19'h0_23A5, 19'h0_2B2A,
      19'h0_3458, 19'h0_3F7A, 19'h0_4CC2, 19'h0_5CF8, 19'h0_70B2,
      19'h0_8886, 19'h0_A56E, 19'h0_C864, 19'h0_F2C6, 19'h1_2624};
   // upper/lower ratio thresholds, fixed point with 8 fraction bits
   localparam logic [11:0] PBO_RATIO_THR [0:14] = '{
      12'h3FA, 12'h2E6, 12'h237, 12'h1BF, 12'h160, 12'h11B, 12'h0E9, 12'h0C0,
      12'h09F, 12'h080, 12'h065, 12'h04F, 12'h03D, 12'h02E, 12'h021};
   typedef enum logic [1:0] {
      PBO_MARGIN_OFF = 2'h0,
      PBO_MARGIN_LOW = 2'h1,
      PBO_MARGIN_HIGH = 2'h2
   } pbo_margin_t;
endpackage

/* File: verification/pbo_host.sv */
// Purpose: management bus host model driving clock and data lines
// Assumes: open drain data line with pull-up, timed off the core clock
// Notes: half bit period of 10 clk keeps well above the device filter
`timescale 1ns/1ps
`default_nettype none
module pbo_host import pbo_pkg::*; (
   // timing clock
   input wire logic clk,
   // resolved data line level
   input wire logic sda_wire,
   // host drive, data 1 releases to the pull-up
   output logic scl,
   output logic sda_rel
);
   initial scl = 1'b1;
   initial sda_rel = 1'b1;
   task automatic hp(input int n = 10);
      repeat (n) @(posedge clk);
   endtask
   // data moves only with clock low, well after its fall
   task automatic bit_io(input logic b, output logic r);
      hp(2);
      sda_rel <= b;
      hp(8);
      scl <= 1'b1;
      hp(5);
      r = sda_wire;
      hp(5);
      scl <= 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(1'b1, r); // release: device acks, or host nacks a read
      ack = !r;
   endtask
   task automatic start();
      hp(2);
      sda_rel <= 1'b1;
      hp(8);
      scl <= 1'b1;
      hp();
      sda_rel <= 1'b0;
      hp();
      scl <= 1'b0;
   endtask
   task automatic stop();
      hp(2);
      sda_rel <= 1'b0;
      hp(8);
      scl <= 1'b1;
      hp();
      sda_rel <= 1'b1;
      hp(40); // spacing before the next frame
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] w, input int n, output logic ok);
      logic [7:0] rx;
      logic k;
      start();
      byte_io({a, 1'b0}, rx, ok);
      byte_io(PBO_CMD_OPERATION, rx, k);
      ok &= k;
      for (int i = 0; i < n; i++) begin
         byte_io(w[8*i +: 8], rx, k);
         ok &= k;
      end
      stop();
   endtask
   // one byte read then nack ends the transfer
   task automatic rd(input logic [7:0] cmd, output logic [7:0] v, output logic ok);
      logic [7:0] rx;
      logic k;
      start();
      byte_io({PBO_ADDR_DEFAULT, 1'b0}, rx, ok);
      byte_io(cmd, rx, k);
      start();
      byte_io({PBO_ADDR_DEFAULT, 1'b1}, rx, ok);
      byte_io(8'hFF, v, k);
      stop();
   endtask
endmodule
`default_nettype wire

/* File: verification/pbo_monitor.sv */
// Purpose: concurrent checks on the command block outputs
// Assumes: all watched outputs live in the clk domain
// Notes: bound to pbo_core, so it sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pbo_monitor import pbo_pkg::*; #(
   parameter int NUM_STRAPS = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration and flag clear
   input wire logic cfg_act_on_inputs,
   input wire logic cfg_use_cmd,
   input wire logic unsupported_clear,
   // converter control
   input wire logic conversion_enable,
   input wire logic soft_stop_sel,
   input wire pbo_margin_t margin_sel,
   input wire logic margin_ignore_fault,
   input wire logic [7:0] operation_value,
   input wire logic unsupported_data,
   // strap codes
   input wire logic strap_done,
   input wire logic [NUM_STRAPS-1:0][3:0] ground_resistor_code,
   input wire logic [NUM_STRAPS-1:0][3:0] divider_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [3:0] mf; // margin field of the stored byte
   assign mf = operation_value[5:2];
   low_bits_a: assert property (operation_value[1:0] == 2'h0)
      else $error("low bits of stored byte not zero");
   soft_stop_a: assert property (soft_stop_sel == operation_value[6])
      else $error("soft stop select differs from stored bit");
   margin_dec_a: assert property (margin_sel == ((mf == PBO_MRG_LOW_IGN ||
      mf == PBO_MRG_LOW_ACT) ? PBO_MARGIN_LOW : (mf == PBO_MRG_HIGH_IGN ||
      mf == PBO_MRG_HIGH_ACT) ? PBO_MARGIN_HIGH : PBO_MARGIN_OFF))
      else $error("margin select wrong for stored field");
   ignore_flag_a: assert property (margin_ignore_fault == (operation_value[7] &&
      (mf == PBO_MRG_LOW_IGN || mf == PBO_MRG_HIGH_IGN)))
      else $error("ignore fault flag wrong");
   // config may pass a register stage, so three stable cycles are asked
   en_free_a: assert property ((!cfg_act_on_inputs) [*3] |-> conversion_enable)
      else $error("conversion off while inputs are ignored");
   en_cmd_off_a: assert property ((cfg_act_on_inputs && cfg_use_cmd &&
      !operation_value[7]) [*3] |-> !conversion_enable)
      else $error("conversion on with command bit clear");
   strap_hold_a: assert property (strap_done && $past(strap_done) |->
      $stable(ground_resistor_code) && $stable(divider_code))
      else $error("strap codes moved after latching");
   unsup_sticky_a: assert property (unsupported_data && !unsupported_clear &&
      !$past(unsupported_clear) |=> unsupported_data)
      else $error("unsupported flag dropped without clear");
   op_valid_a: assert property ($changed(operation_value) |-> (mf <= PBO_MRG_OFF2 ||
      mf == PBO_MRG_LOW_IGN || mf == PBO_MRG_LOW_ACT || mf == PBO_MRG_HIGH_IGN ||
      mf == PBO_MRG_HIGH_ACT))
      else $error("invalid margin code stored");
   // main scenarios reached
   cover property (margin_sel == PBO_MARGIN_HIGH && margin_ignore_fault);
   cover property ($rose(unsupported_data));
   cover property (strap_done && ground_resistor_code[1] == 4'hF);
endmodule
bind pbo_core pbo_monitor #(.NUM_STRAPS(NUM_STRAPS)) mon (.clk(clk), .rst(rst),
   .cfg_act_on_inputs(cfg_act_on_inputs), .cfg_use_cmd(cfg_use_cmd),
   .unsupported_clear(unsupported_clear), .conversion_enable(conversion_enable),
   .soft_stop_sel(soft_stop_sel), .margin_sel(margin_sel),
   .margin_ignore_fault(margin_ignore_fault), .operation_value(operation_value),
   .unsupported_data(unsupported_data), .strap_done(strap_done),
   .ground_resistor_code(ground_resistor_code), .divider_code(divider_code));
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for the power-operation command block
// Assumes: default parameters, host model on the bus pins
// Notes: seeded random writes mixed with refused frames and strap corners
`timescale 1ns/1ps
`default_nettype none
module tb import pbo_pkg::*; ;
   logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
   logic scl, sda_rel, sda_in, sda_out, sda_oe_n;
   logic enable_pin = 1'b0, cfg_act_on_inputs = 1'b0, cfg_use_cmd = 1'b0, cfg_use_pin = 1'b0;
   logic unsupported_clear = 1'b0, strap_sample = 1'b0;
   logic [1:0][PBO_OHM_W-1:0] rbot = '0, rtop = '0;
   logic conversion_enable, soft_stop_sel, margin_ignore_fault, unsupported_data, strap_done;
   pbo_margin_t margin_sel;
   logic [7:0] operation_value;
   logic [1:0][3:0] grc, dvc;
   int err_count = 0, n_compared = 0;
   // nominal lower resistors and upper/lower ratios in Q8
   int RB [16] = '{4640, 5620, 6810, 8250, 10000, 12100, 14700, 17800, 21500, 26100, 31600,
      38300, 46400, 56200, 68100, 82500};
   int RQ [16] = '{1185, 850, 634, 501, 394, 310, 256, 211, 174, 144, 113, 89, 70, 52, 39, 28};
   logic [3:0] VM [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA};
   logic [3:0] BAD [9] = '{4'h3, 4'h4, 4'h7, 4'h8, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
   always #5 clk = ~clk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   // device only pulls low; released line floats high
   assign sda_in = sda_rel & (sda_oe_n | sda_out);
   pbo_host h (.clk(clk), .sda_wire(sda_in), .scl(scl), .sda_rel(sda_rel));
   pbo_core dut (.clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .enable_pin(enable_pin),
      .cfg_act_on_inputs(cfg_act_on_inputs), .cfg_use_cmd(cfg_use_cmd),
      .cfg_use_pin(cfg_use_pin), .unsupported_clear(unsupported_clear),
      .strap_sample(strap_sample), .strap_rbot_ohms(rbot), .strap_rtop_ohms(rtop),
      .conversion_enable(conversion_enable), .soft_stop_sel(soft_stop_sel),
      .margin_sel(margin_sel), .margin_ignore_fault(margin_ignore_fault),
      .operation_value(operation_value), .unsupported_data(unsupported_data),
      .strap_done(strap_done), .ground_resistor_code(grc), .divider_code(dvc));
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // a bounded wait that runs out ends the run as a mismatch
   task automatic tmo(input string nm);
      err_count++;
      $display("[ERR] %s expected done seen timeout", nm);
      summarize();
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [7:0] mdec(input logic [3:0] m);
      return (m == 4'h5 || m == 4'h6) ? 8'h01 : (m == 4'h9 || m == 4'hA) ? 8'h02 : 8'h00;
   endfunction
   function automatic logic [7:0] en_exp(input logic [7:0] v);
      return 8'(!cfg_act_on_inputs || ((!cfg_use_cmd || v[7]) && (!cfg_use_pin || enable_pin)));
   endfunction
   task automatic chk_ctl(input logic [7:0] v);
      chk("op", v, operation_value);
      chk("soft", 8'(v[6]), 8'(soft_stop_sel));
      chk("margin", mdec(v[5:2]), 8'(margin_sel));
      chk("ignore", 8'(v[7] && (v[5:2] == 4'h5 || v[5:2] == 4'h9)), 8'(margin_ignore_fault));
      chk("enable", en_exp(v), 8'(conversion_enable));
   endtask
   // hang guard
   initial begin
      repeat (90000) @(posedge clk);
      tmo("run_limit");
   end
   initial begin
      logic [7:0] v, cur, rv;
      logic ok;
      int g [2], d [2], sel;
      void'($urandom(32'h891b));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk("op_reset", 8'h00, operation_value);
      chk("oe_idle", 8'h01, 8'(sda_oe_n));
      g = '{int'($urandom_range(15)), 15};
      d = '{int'($urandom_range(15)), 0};
      for (int s = 0; s < 2; s++) begin
         rbot[s] <= 19'(RB[g[s]]);
         rtop[s] <= 19'(RB[g[s]] * RQ[d[s]] / 256);
      end
      // second pass swaps resistors: codes must not relatch
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         strap_sample <= 1'b1;
         @(posedge clk);
         strap_sample <= 1'b0;
         for (int i = 0; i < 50 && strap_done !== 1'b1; i++) @(posedge clk);
         if (strap_done !== 1'b1) tmo("strap_wait");
         repeat (5) @(posedge clk);
         for (int s = 0; s < 2; s++) begin
            chk("ground_code", 8'(g[s]), 8'(grc[s]));
            chk("divider_code", 8'(d[s]), 8'(dvc[s]));
         end
         rbot <= {rbot[0], rbot[1]};
         rtop <= {rtop[0], rtop[1]};
      end
      $display("test strap done");
      cur = 8'h00;
      // 0..2 good, 3 bad margin, 4 two data bytes, 5 foreign address
      for (int k = 0; k < 30; k++) begin
         sel = k % 6;
         v = 8'($urandom);
         v[5:2] = (sel == 3) ? BAD[$urandom_range(8)] : VM[$urandom_range(6)];
         @(posedge clk);
         {cfg_act_on_inputs, cfg_use_cmd, cfg_use_pin, enable_pin} <= 4'($urandom);
         unsupported_clear <= 1'b1;
         @(posedge clk);
         unsupported_clear <= 1'b0;
         h.wr((sel == 5) ? 7'h2B : PBO_ADDR_DEFAULT, {24'($urandom), v}, (sel == 4) ? 2 : 1, ok);
         if (sel < 3) cur = v & PBO_OP_WR_MASK;
         for (int i = 0; i < 100 && operation_value !== cur; i++) @(posedge clk);
         if (operation_value !== cur) tmo("op_wait");
         chk("ack", 8'(sel != 5), 8'(ok));
         chk_ctl(cur);
         chk("unsupported", 8'(sel == 3 || sel == 4), 8'(unsupported_data));
         h.rd(PBO_CMD_OPERATION, rv, ok);
         chk("readback", cur, rv);
      end
      $display("test operation done");
      h.rd(8'hD0, rv, ok);
      chk("fill", PBO_RD_FILL, rv);
      $display("test fill done");
      summarize();
   end
endmodule
`default_nettype wire
